// ==== core/adc_irq_consts.vh ====
// Register map, field positions and reset values of the ADC interrupt enables
`ifndef ADC_IRQ_CONSTS_VH
`define ADC_IRQ_CONSTS_VH

// Register byte offsets
`define IRQ_ENABLE_OFS      12'h300
`define IRQ_ENABLE_SET_OFS  12'h304
`define IRQ_ENABLE_CLR_OFS  12'h308
`define EVT_STATUS_OFS      12'h310
`define EVT_STATUS_CLR_OFS  12'h314
`define IRQ_PENDING_OFS     12'h318

// Widths
`define ADDR_W              12
`define DATA_W              32
`define EVT_COUNT           22

// Field positions
`define BIT_CONV_BEGUN      0
`define BIT_BUFFER_END      1
`define BIT_SAMPLE_DONE     2
`define BIT_RESULT_STORED   3
`define BIT_OFFSET_CAL      4
`define BIT_STOP_COMPLETE   5
`define BIT_LIMIT_BASE      6
`define BIT_CHAN7_LOW       21

// Reset values
`define IRQ_ENABLE_RST      22'h000000
`define EVT_STATUS_RST      22'h000000
`define RDATA_RST           32'h00000000

`endif

// ==== core/adc_irq_enable_logic.v ====
// Interrupt enable logic of the ADC: enable bits, set/clear views, irq line
//
// How it works
// [R1] Direct enable register: bit 0 disables, bit 1 enables each event.
// [R2] Writing 1 to a set-register bit enables that event only.
// [R3] Reading the set register returns the current enable of each event.
// [R4] Writing 1 to a clear-register bit disables it; reads match set.
// [R5] Bits 0..5: begun, buffer end, sample, result, calibration, stop.
// [R6] Bits 6..21: high then low limit per channel, channel 0 to 7.
// [R7] Stop-complete enabled by its set bit, disabled by its clear bit.
// [R8] Clearing calibration-done makes both registers read that bit as 0.
// [R9] Writing 0 to set or clear changes nothing; all enables are 0 after reset.
`timescale 1ns/1ps
`include "adc_irq_consts.vh"
module adc_irq_enable_logic (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`ADDR_W-1:0]    paddr,
  input  wire [`DATA_W-1:0]    pwdata,
  input  wire [3:0]            pstrb,
  output wire [`DATA_W-1:0]    prdata,
  output wire                  pready,
  output wire                  pslverr,
  input  wire                  conversionBegunEvt,
  input  wire                  bufferEndEvt,
  input  wire                  sampleDoneEvt,
  input  wire                  resultStoredEvt,
  input  wire                  offsetCalCompleteEvt,
  input  wire                  stopCompleteEvt,
  input  wire [7:0]            chanAboveHighEvt,
  input  wire [7:0]            chanBelowLowEvt,
  output wire [`EVT_COUNT-1:0] irqEnable,
  output wire                  irq
);

  // Handshake strobes
  wire                   accessFirst;
  wire                   writeDone;
  wire                   readDone;

  // Register state
  reg  [`EVT_COUNT-1:0]  enable_reg;
  reg  [`EVT_COUNT-1:0]  enable_next;
  reg  [`DATA_W-1:0]     rdata_reg;
  reg  [`DATA_W-1:0]     rdata_next;
  reg                    slverr_reg;
  reg                    slverr_next;
  reg                    irq_reg;
  reg                    irq_next;

  // Decode
  wire                   hitEnable;
  wire                   hitSet;
  wire                   hitClr;
  wire                   hitStatus;
  wire                   hitStatusClr;
  wire                   hitPending;
  wire                   mapped;
  wire                   aligned;

  // Write data after byte lanes
  wire [`DATA_W-1:0]     laneMask;
  wire [`EVT_COUNT-1:0]  wrBits;
  wire [`EVT_COUNT-1:0]  wrLanes;

  // Events and sticky flags
  wire [`EVT_COUNT-1:0]  evtVector;
  wire [`EVT_COUNT-1:0]  statusClear;
  wire [`EVT_COUNT-1:0]  statusFlags;
  wire [`EVT_COUNT-1:0]  pendingFlags;
  wire [7:0]             limitPairLo;
  wire [7:0]             limitPairHi;

  apb_access_ctl u_apb (
    .clk         (clk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .pready      (pready),
    .accessFirst (accessFirst),
    .writeDone   (writeDone),
    .readDone    (readDone)
  );

  // Address decode on whole aligned words
  assign aligned      = (paddr[1:0] == 2'h0);
  assign hitEnable    = aligned & (paddr == `IRQ_ENABLE_OFS);
  assign hitSet       = aligned & (paddr == `IRQ_ENABLE_SET_OFS);
  assign hitClr       = aligned & (paddr == `IRQ_ENABLE_CLR_OFS);
  assign hitStatus    = aligned & (paddr == `EVT_STATUS_OFS);
  assign hitStatusClr = aligned & (paddr == `EVT_STATUS_CLR_OFS);
  assign hitPending   = aligned & (paddr == `IRQ_PENDING_OFS);
  assign mapped       = hitEnable | hitSet | hitClr | hitStatus |
                        hitStatusClr | hitPending;

  // Byte strobes gate which write bits count
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_lane
      assign laneMask[8*b+7:8*b] = {8{pstrb[b]}};
    end
  endgenerate

  assign wrLanes = laneMask[`EVT_COUNT-1:0];
  assign wrBits  = pwdata[`EVT_COUNT-1:0] & wrLanes;

  // Event vector in field order
  assign evtVector[`BIT_CONV_BEGUN]    = conversionBegunEvt;   // [R5]
  assign evtVector[`BIT_BUFFER_END]    = bufferEndEvt;         // [R5]
  assign evtVector[`BIT_SAMPLE_DONE]   = sampleDoneEvt;        // [R5]
  assign evtVector[`BIT_RESULT_STORED] = resultStoredEvt;      // [R5]
  assign evtVector[`BIT_OFFSET_CAL]    = offsetCalCompleteEvt; // [R5]
  assign evtVector[`BIT_STOP_COMPLETE] = stopCompleteEvt;      // [R5]

  // High limit at even bit, low limit at odd bit of each channel pair
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1) begin : g_chan
      assign evtVector[`BIT_LIMIT_BASE+2*c]   = chanAboveHighEvt[c]; // [R6]
      assign evtVector[`BIT_LIMIT_BASE+2*c+1] = chanBelowLowEvt[c];  // [R6]
      assign limitPairHi[c] = enable_reg[`BIT_LIMIT_BASE+2*c];
      assign limitPairLo[c] = enable_reg[`BIT_LIMIT_BASE+2*c+1];
    end
  endgenerate

  // Status flags cleared by writing 1 to the status clear register
  assign statusClear = (writeDone & hitStatusClr) ? wrBits
                                                  : {`EVT_COUNT{1'b0}};

  evt_sticky_bank u_status (
    .clk       (clk),
    .rst       (rst),
    .evtPulse  (evtVector),
    .clearMask (statusClear),
    .flags     (statusFlags)
  );

  // Enable gates each event onto the interrupt line
  assign pendingFlags = statusFlags & enable_reg; // [R1]

  // Enable bits: direct write, write-one-to-set, write-one-to-clear
  always @* begin
    enable_next = enable_reg;
    if (writeDone) begin
      if (hitEnable) begin
        // Only written byte lanes take the new value
        enable_next = (enable_reg & ~wrLanes) | wrBits; // [R1]
      end else if (hitSet) begin
        // Zero bits leave their enables as they are
        enable_next = enable_reg | wrBits; // [R2] [R7] [R9]
      end else if (hitClr) begin
        // Calibration and stop enables drop here like all others
        enable_next = enable_reg & ~wrBits; // [R4] [R7] [R8] [R9]
      end
    end
  end

  // Read data prepared in the first access cycle, held through completion
  always @* begin
    rdata_next  = rdata_reg;
    slverr_next = slverr_reg;
    if (accessFirst) begin
      rdata_next  = `RDATA_RST;
      slverr_next = ~mapped;
      if (~pwrite) begin
        case (1'b1)
          hitEnable: begin
            rdata_next[`EVT_COUNT-1:0] = enable_reg; // [R1]
          end
          hitSet: begin
            rdata_next[`EVT_COUNT-1:0] = enable_reg; // [R3]
          end
          hitClr: begin
            rdata_next[`EVT_COUNT-1:0] = enable_reg; // [R4] [R8]
          end
          hitStatus: begin
            rdata_next[`EVT_COUNT-1:0] = statusFlags;
          end
          hitPending: begin
            rdata_next[`EVT_COUNT-1:0] = pendingFlags;
          end
          default: begin
            rdata_next = `RDATA_RST;
          end
        endcase
      end
    end else if (readDone | writeDone) begin
      rdata_next  = `RDATA_RST;
      slverr_next = 1'b0;
    end
  end

  // Level interrupt while any enabled status flag is set
  always @* begin
    irq_next = |pendingFlags; // [R1]
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= `IRQ_ENABLE_RST; // [R9]
      rdata_reg  <= `RDATA_RST;
      slverr_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      rdata_reg  <= rdata_next;
      slverr_reg <= slverr_next;
      irq_reg    <= irq_next;
    end
  end

  assign prdata    = rdata_reg;
  assign pslverr   = slverr_reg;
  assign irqEnable = enable_reg;
  assign irq       = irq_reg;

endmodule // adc_irq_enable_logic

// ==== core/apb_access_ctl.v ====
// APB slave handshake: one wait state, completion strobes for the register file
`timescale 1ns/1ps
module apb_access_ctl (
  input  wire clk,
  input  wire rst,
  input  wire psel,
  input  wire penable,
  input  wire pwrite,
  output wire pready,
  output wire accessFirst,
  output wire writeDone,
  output wire readDone
);

  reg readyReg;
  reg readyNext;

  // First access cycle: read data and error are prepared here
  assign accessFirst = psel & penable & ~readyReg;
  // Completion edge: pready sampled high
  assign writeDone   = psel & penable & readyReg & pwrite;
  assign readDone    = psel & penable & readyReg & ~pwrite;
  assign pready      = readyReg;

  always @* begin
    readyNext = accessFirst;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readyReg <= 1'b0;
    end else begin
      readyReg <= readyNext;
    end
  end

endmodule // apb_access_ctl

// ==== core/evt_sticky_bank.v ====
// Sticky event flags, one per event, set wins over a simultaneous clear
`timescale 1ns/1ps
`include "adc_irq_consts.vh"
module evt_sticky_bank (
  input  wire                    clk,
  input  wire                    rst,
  input  wire [`EVT_COUNT-1:0]   evtPulse,
  input  wire [`EVT_COUNT-1:0]   clearMask,
  output wire [`EVT_COUNT-1:0]   flags
);

  genvar i;
  generate
    for (i = 0; i < `EVT_COUNT; i = i + 1) begin : g_flag
      reg flagReg;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          flagReg <= 1'b0;
        end else begin
          flagReg <= evtPulse[i] | (flagReg & ~clearMask[i]);
        end
      end
      assign flags[i] = flagReg;
    end
  endgenerate

endmodule // evt_sticky_bank

// ==== sim/adc_irq_enable_chk.sv ====
// Port assertions for the ADC interrupt enable block
`timescale 1ns/1ps
module adc_irq_enable_chk (
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic [21:0] irqEnable,
  input logic        irq
);
  wire        wrOk = psel && penable && pready && pwrite && pstrb == 4'hF;
  wire        rdOk = psel && penable && pready && !pwrite;
  wire [21:0] wLow = pwdata[21:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_set_ors: assert property (wrOk && paddr == 12'h304 |=>
    irqEnable == ($past(irqEnable) | $past(wLow))) else $error("set wrong");
  a_clear_masks: assert property (wrOk && paddr == 12'h308 |=>
    irqEnable == ($past(irqEnable) & ~$past(wLow))) else $error("clr wrong");
  a_direct_load: assert property (wrOk && paddr == 12'h300 |=>
    irqEnable == $past(wLow)) else $error("direct write wrong");
  a_enable_holds: assert property (!(psel && penable && pready && pwrite)
    |=> $stable(irqEnable)) else $error("enable moved");
  a_read_set: assert property (rdOk && paddr == 12'h304 |->
    prdata == {10'h000, irqEnable}) else $error("set read wrong");
  a_read_clear: assert property (rdOk && paddr == 12'h308 |->
    prdata == {10'h000, irqEnable}) else $error("clr read wrong");
  a_ready_wait: assert property ($rose(psel && penable) |->
    !pready ##1 pready) else $error("pready timing wrong");
  a_irq_enabled: assert property (irq |->
    $past(irqEnable) != 22'h0) else $error("irq without enable");
  c_set: cover property (wrOk && paddr == 12'h304);
  c_clear: cover property (wrOk && paddr == 12'h308);
  c_irq: cover property ($rose(irq));
endmodule // adc_irq_enable_chk

bind adc_irq_enable_logic adc_irq_enable_chk adc_irq_enable_chk_inst (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .irqEnable(irqEnable), .irq(irq));

// ==== sim/tb_adc_irq_enable_logic.sv ====
// Self-checking bench for the ADC interrupt enable block
`timescale 1ns/1ps
module tb_adc_irq_enable_logic;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, bitMask;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, irq, err;
  logic [21:0] evt = 22'h0, irqEnable;
  logic [7:0]  hi, lo;
  int          n_mismatch = 0, cmp_count = 0;

  always_comb
    for (int c = 0; c < 8; c++) begin
      hi[c] = evt[6 + 2 * c];
      lo[c] = evt[7 + 2 * c];
    end

  adc_irq_enable_logic adc_irq_enable_logic_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conversionBegunEvt(evt[0]),
    .bufferEndEvt(evt[1]), .sampleDoneEvt(evt[2]),
    .resultStoredEvt(evt[3]), .offsetCalCompleteEvt(evt[4]),
    .stopCompleteEvt(evt[5]), .chanAboveHighEvt(hi),
    .chanBelowLowEvt(lo), .irqEnable(irqEnable), .irq(irq));

  initial forever #4 clk = ~clk;

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(12'h304, 1'b0, 32'h0);
    check("set after reset", rd, 32'h0);
    apb(12'h300, 1'b1, 32'h003FFFFF);
    apb(12'h304, 1'b1, 32'h0);
    apb(12'h308, 1'b1, 32'h0);
    apb(12'h308, 1'b0, 32'h0);
    check("zero writes", rd, 32'h003FFFFF);
    apb(12'h0FC, 1'b0, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    for (int i = 0; i < 22; i++) begin
      bitMask = 32'h1 << i;
      apb(12'h314, 1'b1, 32'hFFFFFFFF);
      apb(12'h300, 1'b1, 32'h003FFFFF & ~bitMask);
      @(posedge clk) evt <= bitMask[21:0];
      @(posedge clk) evt <= 22'h0;
      repeat (3) @(posedge clk);
      check("masked irq", {31'h0, irq}, 32'h0);
      apb(12'h304, 1'b1, bitMask);
      repeat (2) @(posedge clk);
      check("irq on", {31'h0, irq}, 32'h1);
      apb(12'h304, 1'b0, 32'h0);
      check("set read", rd, 32'h003FFFFF);
      apb(12'h308, 1'b1, bitMask);
      apb(12'h308, 1'b0, 32'h0);
      check("clr read", rd, 32'h003FFFFF & ~bitMask);
      repeat (2) @(posedge clk);
      check("irq off", {31'h0, irq}, 32'h0);
    end
    tally_and_finish();
  end
endmodule // tb_adc_irq_enable_logic
